// ---- rtl/src_ctrl.sv ----
// starter parameter bank, start/stop gating, calendar, fault history and run meters
// Summary of operation
// RL1: format 0 off, 1 eleven-bit parity, 2 ten-bit
// RL2: bit rate 4.8/9.6/19.2k, default 9.6k
// RL3: node address 1..247, default 1, match only
// RL4: host gives every node unique address
// RL5: mode 0 monitors only, ignores serial start/stop
// RL6: modes 1,2 start needs wired and serial
// RL7: modes 1,2 stop on either stop
// RL8: mode 3 remote/local input picks mode 1/0
// RL9: no jog while input is remote/local
// RL10: lock code 0..999, zero means unprotected
// RL11: emergency clear reverts to zero itself
// RL12: clear 1 zeroes thermal and lockouts
// RL13: clear 2 restores defaults, erases history
// RL14: factory restore keeps lock code
// RL15: calendar 2000-2047 with leap years
// RL16: no daylight saving correction
// RL17: three fault entries, code 0..57, stamps; code 0 is not logged
// RL18: stamps hh.mm and mm.dd, empty reads zero
// RL19: run time counts accel, run, decel, jog
// RL20: run count advances at at-speed entry
// RL21: tenth-hours to 999.9, overflow to thousands
// RL22: counts to 9999, overflow to ten-thousands
// RL23: new fault shifts history down one slot
// RL24: out-of-range writes are ignored; only low 8 or 16 data bits are checked, jog function takes bit 0 of any value
//
// Local design decisions: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps
`include "src_defs.svh"
module src_ctrl import src_pkg::*; #(
   parameter int CLK_HZ = `SRC_CLK_HZ,
   parameter int TENTH_HR_S = `SRC_TENTH_HR_S
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // serial frame address check
   input wire logic [7:0] frame_addr_i,
   output logic frame_match_o,
   // start/stop sources
   input wire logic wired_start_i,
   input wire logic wired_stop_i,
   input wire logic jog_pin_i,
   input wire logic serial_start_i,
   input wire logic serial_stop_i,
   // starter state
   input wire logic accel_i,
   input wire logic running_i,
   input wire logic decel_i,
   input wire logic jogging_i,
   input wire logic at_speed_i,
   // fault capture
   input wire logic fault_i,
   input wire logic [5:0] fault_code_i,
   // commands and link setup
   output logic start_cmd_o,
   output logic stop_cmd_o,
   output logic jog_cmd_o,
   output logic comm_enable_o,
   output logic parity_en_o,
   output logic [1:0] link_bit_rate_o,
   output logic emergency_clear_o,
   output logic locked_o
);
   // the product outgrows 32 bits at the default clock, so it is worked out in 64
   localparam longint TICKS_PER_TENTH = longint'(CLK_HZ) * longint'(TENTH_HR_S);
   localparam int SEC_TICKS = CLK_HZ;

   typedef struct packed {
      src_bus_t bus;
      logic [31:0] rdata;
      logic [1:0] comm_format_select;
      logic [1:0] link_bit_rate_select;
      logic [7:0] node_address_setting;
      logic [1:0] remote_control_mode;
      logic [9:0] parameter_lock_code;
      logic unlocked;
      logic [1:0] emergency_clear_cmd;
      logic clear_pulse;
      logic jog_input_function;
      logic [10:0] clock_year;
      logic [3:0] clock_month;
      logic [4:0] clock_day;
      logic [4:0] clock_hour;
      logic [5:0] clock_minute;
      logic [5:0] clock_second;
      logic [31:0] sec_cnt;
      logic [33:0] tenth_cnt;
      src_fault_t [2:0] hist;
      logic [13:0] run_hours_low;
      logic [13:0] run_hours_thousands;
      logic [13:0] run_count_low;
      logic [13:0] run_count_ten_thousands;
      logic at_speed_q;
      logic fault_q;
      logic [2:0] jog_sync;
      logic jog_closed;
   } src_state_t;

   src_state_t s;
   src_state_t next_s;
   logic [4:0] days_in_month;
   logic leap;
   logic remote_on;
   logic wr;
   logic [7:0] d8;
   logic [15:0] d16;

   // months have variable length; every fourth year in range is leap
   always_comb begin
      leap = (s.clock_year[1:0] == 2'd0); // RL15
      case (s.clock_month)
         4'd2: days_in_month = leap ? 5'd29 : 5'd28; // RL15
         4'd4, 4'd6, 4'd9, 4'd11: days_in_month = 5'd30;
         default: days_in_month = 5'd31;
      endcase
   end

   // effective remote mode; mode 3 follows the remote/local input
   always_comb begin
      case (s.remote_control_mode)
         2'd1, 2'd2: remote_on = (s.comm_format_select != 2'd0);
         2'd3: remote_on = (s.comm_format_select != 2'd0) && s.jog_input_function
                           && s.jog_closed; // RL8
         default: remote_on = 1'b0; // RL5
      endcase
   end

   assign start_cmd_o = remote_on ? (wired_start_i && serial_start_i) : wired_start_i; // RL6
   assign stop_cmd_o = remote_on ? (wired_stop_i || serial_stop_i) : wired_stop_i; // RL7
   assign jog_cmd_o = s.jog_input_function ? 1'b0 : s.jog_closed; // RL9
   assign comm_enable_o = (s.comm_format_select != 2'd0); // RL1
   assign parity_en_o = (s.comm_format_select == 2'd1); // RL1
   assign link_bit_rate_o = s.link_bit_rate_select; // RL2
   assign frame_match_o = comm_enable_o && (frame_addr_i == s.node_address_setting); // RL3
   assign emergency_clear_o = s.clear_pulse; // RL12
   assign locked_o = (s.parameter_lock_code != 10'd0) && !s.unlocked; // RL10
   assign ack_o = (s.bus == SRC_ACK);
   assign dat_o = s.rdata;

   always_comb begin
      next_s = s;
      wr = cyc_i && stb_i && we_i && (s.bus == SRC_IDLE) && sel_i[0];
      d8 = dat_i[7:0];
      d16 = dat_i[15:0];
      next_s.bus = (cyc_i && stb_i && s.bus == SRC_IDLE) ? SRC_ACK : SRC_IDLE;
      next_s.clear_pulse = 1'b0;
      next_s.jog_sync = {s.jog_sync[1:0], jog_pin_i};
      if (s.jog_sync[2] == s.jog_sync[1]) begin
         next_s.jog_closed = s.jog_sync[2];
      end
      next_s.at_speed_q = at_speed_i;
      next_s.fault_q = fault_i;

      // calendar, plain local time with no seasonal shift
      if (s.sec_cnt == 32'(SEC_TICKS - 1)) begin
         next_s.sec_cnt = '0;
         next_s.clock_second = s.clock_second + 6'd1; // RL16
         if (s.clock_second == `SRC_MINSEC_MAX) begin
            next_s.clock_second = '0;
            next_s.clock_minute = s.clock_minute + 6'd1;
            if (s.clock_minute == `SRC_MINSEC_MAX) begin
               next_s.clock_minute = '0;
               next_s.clock_hour = s.clock_hour + 5'd1;
               if (s.clock_hour == `SRC_HOUR_MAX) begin
                  next_s.clock_hour = '0; // RL15
                  next_s.clock_day = s.clock_day + 5'd1;
                  if (s.clock_day >= days_in_month) begin
                     next_s.clock_day = `SRC_DEF_DAY;
                     next_s.clock_month = s.clock_month + 4'd1;
                     if (s.clock_month == `SRC_MONTH_MAX) begin
                        next_s.clock_month = 4'd1;
                        next_s.clock_year = (s.clock_year == `SRC_YEAR_MAX) ?
                           `SRC_YEAR_MIN : s.clock_year + 11'd1; // RL15
                     end
                  end
               end
            end
         end
      end else begin
         next_s.sec_cnt = s.sec_cnt + 32'd1;
      end

      // run time in tenth hours while the motor is driven
      if (accel_i || running_i || decel_i || jogging_i) begin // RL19
         if (s.tenth_cnt == 34'(TICKS_PER_TENTH - 1)) begin
            next_s.tenth_cnt = '0;
            if (s.run_hours_low == `SRC_TENTH_MAX) begin
               next_s.run_hours_low = '0; // RL21
               next_s.run_hours_thousands = (s.run_hours_thousands == `SRC_CNT_MAX) ?
                  14'd0 : s.run_hours_thousands + 14'd1; // RL21
            end else begin
               next_s.run_hours_low = s.run_hours_low + 14'd1;
            end
         end else begin
            next_s.tenth_cnt = s.tenth_cnt + 34'd1;
         end
      end

      if (at_speed_i && !s.at_speed_q) begin // RL20
         if (s.run_count_low == `SRC_CNT_MAX) begin
            next_s.run_count_low = '0; // RL22
            next_s.run_count_ten_thousands = (s.run_count_ten_thousands == `SRC_CNT_MAX) ?
               14'd0 : s.run_count_ten_thousands + 14'd1; // RL22
         end else begin
            next_s.run_count_low = s.run_count_low + 14'd1;
         end
      end

      // fault log on rising fault; codes above range are dropped
      if (fault_i && !s.fault_q && fault_code_i <= `SRC_FAULT_MAX
          && fault_code_i != 6'd0) begin // RL17
         next_s.hist[2] = s.hist[1]; // RL23
         next_s.hist[1] = s.hist[0]; // RL23
         next_s.hist[0].code = fault_code_i;
         next_s.hist[0].tstamp = {3'd0, s.clock_hour, 2'd0, s.clock_minute}; // RL18
         next_s.hist[0].dstamp = {4'd0, s.clock_month, 3'd0, s.clock_day}; // RL18
      end

      // software writes; a locked bank only takes the unlock word
      if (wr && adr_i == `SRC_A_UNLOCK) begin
         next_s.unlocked = ({dat_i[9:0]} == s.parameter_lock_code);
      end
      if (wr && !locked_o) begin
         case (adr_i)
            `SRC_A_FMT: if (d8 <= 8'(`SRC_FMT_MAX)) next_s.comm_format_select = d8[1:0]; // RL24
            `SRC_A_BAUD: if (d8 <= 8'(`SRC_BAUD_192)) next_s.link_bit_rate_select = d8[1:0]; // RL24
            `SRC_A_ADDR: if (d8 >= `SRC_ADDR_MIN && d8 <= `SRC_ADDR_MAX)
               next_s.node_address_setting = d8; // RL3
            `SRC_A_RMODE: if (d8 <= 8'd3) next_s.remote_control_mode = d8[1:0]; // RL24
            `SRC_A_LOCK: if (d16 <= 16'(`SRC_LOCK_MAX)) begin
               next_s.parameter_lock_code = d16[9:0]; // RL10
               next_s.unlocked = 1'b0;
            end
            `SRC_A_ECLR: if (d8 <= 8'd2) next_s.emergency_clear_cmd = d8[1:0]; // RL11
            `SRC_A_JOGF: next_s.jog_input_function = d8[0];
            `SRC_A_YEAR: if (d16 >= 16'(`SRC_YEAR_MIN) && d16 <= 16'(`SRC_YEAR_MAX))
               next_s.clock_year = d16[10:0]; // RL24
            `SRC_A_MONTH: if (d8 >= 8'd1 && d8 <= 8'(`SRC_MONTH_MAX))
               next_s.clock_month = d8[3:0]; // RL24
            `SRC_A_DAY: if (d8 >= 8'd1 && d8 <= 8'd31) next_s.clock_day = d8[4:0]; // RL24
            `SRC_A_HOUR: if (d8 <= 8'(`SRC_HOUR_MAX)) next_s.clock_hour = d8[4:0]; // RL24
            `SRC_A_MIN: if (d8 <= 8'(`SRC_MINSEC_MAX)) next_s.clock_minute = d8[5:0]; // RL24
            `SRC_A_SEC: if (d8 <= 8'(`SRC_MINSEC_MAX)) begin
               next_s.clock_second = d8[5:0]; // RL24
               next_s.sec_cnt = '0;
            end
            default: begin
            end
         endcase
      end

      // one-shot clear executes the cycle after it is stored
      case (s.emergency_clear_cmd)
         2'd1: begin
            next_s.clear_pulse = 1'b1; // RL12
            next_s.emergency_clear_cmd = 2'd0; // RL11
         end
         2'd2: begin
            next_s.comm_format_select = 2'd0; // RL13
            next_s.link_bit_rate_select = `SRC_BAUD_96;
            next_s.node_address_setting = `SRC_ADDR_MIN;
            next_s.remote_control_mode = 2'd0;
            next_s.jog_input_function = 1'b0;
            next_s.hist = '0; // RL13
            next_s.emergency_clear_cmd = 2'd0; // RL11
            // lock code deliberately untouched so a reset cannot bypass it
            next_s.parameter_lock_code = s.parameter_lock_code; // RL14
         end
         default: begin
         end
      endcase

      // read mux
      next_s.rdata = '0;
      if (cyc_i && stb_i && !we_i && s.bus == SRC_IDLE) begin
         case (adr_i)
            `SRC_A_FMT: next_s.rdata = 32'(s.comm_format_select);
            `SRC_A_BAUD: next_s.rdata = 32'(s.link_bit_rate_select);
            `SRC_A_ADDR: next_s.rdata = 32'(s.node_address_setting);
            `SRC_A_RMODE: next_s.rdata = 32'(s.remote_control_mode);
            `SRC_A_LOCK: next_s.rdata = 32'(s.parameter_lock_code);
            `SRC_A_ECLR: next_s.rdata = 32'(s.emergency_clear_cmd);
            `SRC_A_YEAR: next_s.rdata = 32'(s.clock_year);
            `SRC_A_MONTH: next_s.rdata = 32'(s.clock_month);
            `SRC_A_DAY: next_s.rdata = 32'(s.clock_day);
            `SRC_A_HOUR: next_s.rdata = 32'(s.clock_hour);
            `SRC_A_MIN: next_s.rdata = 32'(s.clock_minute);
            `SRC_A_SEC: next_s.rdata = 32'(s.clock_second);
            `SRC_A_F1CODE: next_s.rdata = 32'(s.hist[0].code); // RL17
            `SRC_A_F1TIME: next_s.rdata = 32'(s.hist[0].tstamp);
            `SRC_A_F1DATE: next_s.rdata = 32'(s.hist[0].dstamp);
            `SRC_A_F2CODE: next_s.rdata = 32'(s.hist[1].code);
            `SRC_A_F2TIME: next_s.rdata = 32'(s.hist[1].tstamp);
            `SRC_A_F2DATE: next_s.rdata = 32'(s.hist[1].dstamp);
            `SRC_A_F3CODE: next_s.rdata = 32'(s.hist[2].code);
            `SRC_A_F3TIME: next_s.rdata = 32'(s.hist[2].tstamp);
            `SRC_A_F3DATE: next_s.rdata = 32'(s.hist[2].dstamp);
            `SRC_A_HRLO: next_s.rdata = 32'(s.run_hours_low);
            `SRC_A_HRK: next_s.rdata = 32'(s.run_hours_thousands);
            `SRC_A_CNLO: next_s.rdata = 32'(s.run_count_low);
            `SRC_A_CNK: next_s.rdata = 32'(s.run_count_ten_thousands);
            `SRC_A_JOGF: next_s.rdata = 32'(s.jog_input_function);
            `SRC_A_STAT: next_s.rdata = {28'd0, s.jog_closed, remote_on, locked_o,
                                         comm_enable_o};
            default: next_s.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
         s.link_bit_rate_select <= `SRC_BAUD_96; // RL2
         s.node_address_setting <= `SRC_ADDR_MIN; // RL3
         s.clock_year <= `SRC_YEAR_MIN;
         s.clock_month <= 4'd1;
         s.clock_day <= `SRC_DEF_DAY;
      end else begin
         s <= next_s;
      end
   end
endmodule : src_ctrl

// ---- rtl/src_defs.svh ----
// constants for the starter remote control and history block
`ifndef SRC_DEFS_SVH
`define SRC_DEFS_SVH
// register byte offsets
`define SRC_A_FMT 8'h00
`define SRC_A_BAUD 8'h04
`define SRC_A_ADDR 8'h08
`define SRC_A_RMODE 8'h0c
`define SRC_A_LOCK 8'h10
`define SRC_A_ECLR 8'h14
`define SRC_A_YEAR 8'h18
`define SRC_A_MONTH 8'h1c
`define SRC_A_DAY 8'h20
`define SRC_A_HOUR 8'h24
`define SRC_A_MIN 8'h28
`define SRC_A_SEC 8'h2c
`define SRC_A_F1CODE 8'h30
`define SRC_A_F1TIME 8'h34
`define SRC_A_F1DATE 8'h38
`define SRC_A_F2CODE 8'h3c
`define SRC_A_F2TIME 8'h40
`define SRC_A_F2DATE 8'h44
`define SRC_A_F3CODE 8'h48
`define SRC_A_F3TIME 8'h4c
`define SRC_A_F3DATE 8'h50
`define SRC_A_HRLO 8'h54
`define SRC_A_HRK 8'h58
`define SRC_A_CNLO 8'h5c
`define SRC_A_CNK 8'h60
`define SRC_A_JOGF 8'h64
`define SRC_A_UNLOCK 8'h68
`define SRC_A_STAT 8'h6c
// ranges and defaults
`define SRC_FMT_MAX 2'd2
`define SRC_BAUD_48 2'd0
`define SRC_BAUD_96 2'd1
`define SRC_BAUD_192 2'd2
`define SRC_ADDR_MIN 8'd1
`define SRC_ADDR_MAX 8'd247
`define SRC_LOCK_MAX 10'd999
`define SRC_YEAR_MIN 11'd2000
`define SRC_YEAR_MAX 11'd2047
`define SRC_MONTH_MAX 4'd12
`define SRC_HOUR_MAX 5'd23
`define SRC_MINSEC_MAX 6'd59
`define SRC_FAULT_MAX 6'd57
`define SRC_TENTH_MAX 14'd9999
`define SRC_CNT_MAX 14'd9999
`define SRC_CLK_HZ 40000000
`define SRC_TENTH_HR_S 360
`define SRC_DEF_DAY 5'd1
`endif

// ---- rtl/src_pkg.sv ----
// types for the starter remote control and history block
package src_pkg;
   typedef enum logic [1:0] {
      SRC_IDLE = 2'b00,
      SRC_ACK = 2'b01
   } src_bus_t;
   typedef struct packed {
      logic [5:0] code;
      logic [15:0] tstamp;
      logic [15:0] dstamp;
   } src_fault_t;
endpackage : src_pkg

// ---- tb/src_ctrl_monitor.sv ----
// port-level assertion checker for the starter control block
`timescale 1ns/100ps
module src_ctrl_monitor (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   // frame and commands
   input wire logic [7:0] frame_addr_i,
   input wire logic frame_match_o,
   input wire logic wired_start_i,
   input wire logic wired_stop_i,
   input wire logic start_cmd_o,
   input wire logic stop_cmd_o,
   input wire logic comm_enable_o,
   input wire logic parity_en_o,
   input wire logic [1:0] link_bit_rate_o,
   input wire logic emergency_clear_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_taken;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence s_pulse;
      ack_o ##1 !ack_o;
   endsequence
   property p_ack; s_taken |=> s_pulse; endproperty
   property p_dat; !ack_o |-> dat_o == 32'h0; endproperty
   property p_start; start_cmd_o |-> wired_start_i; endproperty
   property p_stop; wired_stop_i |-> stop_cmd_o; endproperty
   property p_match;
      frame_match_o |-> comm_enable_o && frame_addr_i != 8'h0 && frame_addr_i <= 8'hf7;
   endproperty
   property p_par; parity_en_o |-> comm_enable_o; endproperty
   property p_rate; link_bit_rate_o != 2'h3; endproperty
   property p_eclr; emergency_clear_o |=> !emergency_clear_o; endproperty
   a_ack: assert property (p_ack) else $error("ack not a single pulse after request");
   a_dat: assert property (p_dat) else $error("read data not zero outside ack");
   a_start: assert property (p_start) else $error("start without wired start");
   a_stop: assert property (p_stop) else $error("wired stop did not stop");
   a_match: assert property (p_match) else $error("frame match out of range");
   a_par: assert property (p_par) else $error("parity with link off");
   a_rate: assert property (p_rate) else $error("bit rate code invalid");
   a_eclr: assert property (p_eclr) else $error("clear pulse too long");
endmodule : src_ctrl_monitor
bind src_ctrl src_ctrl_monitor u_mon (.clk_i, .rst_i, .cyc_i, .stb_i, .dat_o, .ack_o,
   .frame_addr_i, .frame_match_o, .wired_start_i, .wired_stop_i, .start_cmd_o,
   .stop_cmd_o, .comm_enable_o, .parity_en_o, .link_bit_rate_o, .emergency_clear_o);

// ---- tb/src_host.sv ----
// host model: decoded serial frame toward the starter
`timescale 1ns/100ps
module src_host (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // requests from the bench
   input wire logic [7:0] addr_req_i,
   input wire logic start_req_i,
   input wire logic stop_req_i,
   // decoded frame
   output logic [7:0] frame_addr_o,
   output logic serial_start_o,
   output logic serial_stop_o
);
   // only decoded frames are modelled; the host is assumed at the starter's rate
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         frame_addr_o <= 8'h00;
         serial_start_o <= 1'b0;
         serial_stop_o <= 1'b0;
      end else begin
         frame_addr_o <= addr_req_i;
         serial_start_o <= start_req_i;
         serial_stop_o <= stop_req_i;
      end
   end
endmodule : src_host

// ---- tb/src_ctrl_tb_top.sv ----
// self-checking bench for the starter control block
`timescale 1ns/100ps
`include "src_defs.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module src_ctrl_tb_top;
   typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} src_row_t;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, fault_i = 1'b0;
   logic [7:0] adr_i = 8'h00, h_addr = 8'h00, frame_addr_i;
   logic [31:0] dat_i = 32'h0, dat_o, q;
   logic [5:0] fault_code_i = 6'h00;
   logic wired_start_i = 1'b0, wired_stop_i = 1'b0, jog_pin_i = 1'b0, h_start = 1'b0;
   logic h_stop = 1'b0, accel_i = 1'b0, running_i = 1'b0, at_speed_i = 1'b0;
   logic ack_o, frame_match_o, start_cmd_o, stop_cmd_o, jog_cmd_o, comm_enable_o;
   logic parity_en_o, emergency_clear_o, locked_o, serial_start_i, serial_stop_i;
   logic [1:0] link_bit_rate_o;
   int err_total = 0, total_checks = 0, eclr_cnt = 0;
   src_row_t rows [14] = '{'{`SRC_A_FMT, 1, 1}, '{`SRC_A_FMT, 3, 1},
      '{`SRC_A_BAUD, 0, 0}, '{`SRC_A_BAUD, 2, 2}, '{`SRC_A_BAUD, 3, 2},
      '{`SRC_A_ADDR, 247, 247}, '{`SRC_A_ADDR, 0, 247}, '{`SRC_A_ADDR, 248, 247},
      '{`SRC_A_RMODE, 2, 2}, '{`SRC_A_RMODE, 4, 2}, '{`SRC_A_YEAR, 2047, 2047},
      '{`SRC_A_YEAR, 1999, 2047}, '{`SRC_A_MONTH, 12, 12}, '{`SRC_A_MONTH, 13, 12}};
   src_ctrl #(.CLK_HZ(10), .TENTH_HR_S(1)) dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
      .adr_i, .sel_i(4'hf), .dat_i, .dat_o, .ack_o, .frame_addr_i, .frame_match_o,
      .wired_start_i, .wired_stop_i, .jog_pin_i, .serial_start_i, .serial_stop_i,
      .accel_i, .running_i, .decel_i(1'b0), .jogging_i(1'b0), .at_speed_i, .fault_i,
      .fault_code_i, .start_cmd_o, .stop_cmd_o, .jog_cmd_o, .comm_enable_o,
      .parity_en_o, .link_bit_rate_o, .emergency_clear_o, .locked_o);
   src_host u_host (.clk_i, .rst_i, .addr_req_i(h_addr), .start_req_i(h_start),
      .stop_req_i(h_stop), .frame_addr_o(frame_addr_i), .serial_start_o(serial_start_i),
      .serial_stop_o(serial_stop_i));
   always #12.5 clk_i = ~clk_i;
   always @(posedge clk_i) if (emergency_clear_o === 1'b1) eclr_cnt++;
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : wrap_up
   // one classic cycle; the wait is bounded so a dead slave ends the run
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      if (n >= 20) begin
         err_total++;
         wrap_up();
      end
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      `CHK(q, e)
   endtask : rd
   task automatic ctl(input logic ws, input logic wp, input logic ss, input logic sp);
      @(posedge clk_i);
      wired_start_i <= ws;
      wired_stop_i <= wp;
      h_start <= ss;
      h_stop <= sp;
      repeat (3) @(posedge clk_i);
      #1;
   endtask : ctl
   task automatic flt(input logic [5:0] c);
      @(posedge clk_i);
      fault_i <= 1'b1;
      fault_code_i <= c;
      @(posedge clk_i);
      fault_i <= 1'b0;
      @(posedge clk_i);
   endtask : flt
   initial begin
      repeat (90000) @(posedge clk_i);
      err_total++;
      wrap_up();
   end
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(`SRC_A_FMT, 32'h0);
      rd(`SRC_A_BAUD, 32'h1);
      rd(`SRC_A_ADDR, 32'h1);
      rd(`SRC_A_F1TIME, 32'h0);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a, rows[i].e);
      end
      rd(8'h70, 32'h0);
      ctl(1'b0, 1'b0, 1'b0, 1'b0);
      `CHK({comm_enable_o, parity_en_o, link_bit_rate_o}, 4'he)
      h_addr <= 8'hf7;
      ctl(1'b0, 1'b0, 1'b0, 1'b0);
      `CHK(frame_match_o, 1'b1)
      h_addr <= 8'h05;
      ctl(1'b0, 1'b0, 1'b0, 1'b0);
      `CHK(frame_match_o, 1'b0)
      wr(`SRC_A_RMODE, 0);
      ctl(1'b0, 1'b0, 1'b1, 1'b1);
      `CHK({start_cmd_o, stop_cmd_o}, 2'b00)
      wr(`SRC_A_RMODE, 1);
      ctl(1'b1, 1'b0, 1'b0, 1'b0);
      `CHK(start_cmd_o, 1'b0)
      ctl(1'b1, 1'b0, 1'b1, 1'b0);
      `CHK(start_cmd_o, 1'b1)
      ctl(1'b0, 1'b0, 1'b0, 1'b1);
      `CHK(stop_cmd_o, 1'b1)
      wr(`SRC_A_RMODE, 3);
      wr(`SRC_A_JOGF, 1);
      ctl(1'b0, 1'b0, 1'b0, 1'b1);
      `CHK(stop_cmd_o, 1'b0)
      jog_pin_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      ctl(1'b0, 1'b0, 1'b0, 1'b1);
      `CHK({stop_cmd_o, jog_cmd_o}, 2'b10)
      ctl(1'b0, 1'b0, 1'b0, 1'b0);
      wr(`SRC_A_MONTH, 9);
      wr(`SRC_A_DAY, 3);
      wr(`SRC_A_HOUR, 15);
      wr(`SRC_A_MIN, 19);
      wr(`SRC_A_SEC, 0);
      flt(6'd5);
      flt(6'd7);
      flt(6'd57);
      rd(`SRC_A_F1CODE, 57);
      rd(`SRC_A_F2CODE, 7);
      rd(`SRC_A_F3CODE, 5);
      rd(`SRC_A_F1TIME, 32'h0f13);
      rd(`SRC_A_F1DATE, 32'h0903);
      repeat (3) begin
         @(posedge clk_i);
         at_speed_i <= 1'b1;
         @(posedge clk_i);
         at_speed_i <= 1'b0;
      end
      rd(`SRC_A_CNLO, 3);
      accel_i <= 1'b1;
      running_i <= 1'b1;
      repeat (40) @(posedge clk_i);
      accel_i <= 1'b0;
      running_i <= 1'b0;
      wb(1'b0, `SRC_A_HRLO, 32'h0);
      `CHK(q != 32'h0, 1'b1)
      wr(`SRC_A_LOCK, 5);
      #1;
      `CHK(locked_o, 1'b1)
      wr(`SRC_A_FMT, 2);
      rd(`SRC_A_FMT, 1);
      wr(`SRC_A_UNLOCK, 5);
      #1;
      `CHK(locked_o, 1'b0)
      wr(`SRC_A_ECLR, 1);
      rd(`SRC_A_ECLR, 0);
      `CHK(eclr_cnt, 1)
      wr(`SRC_A_ECLR, 2);
      rd(`SRC_A_FMT, 0);
      rd(`SRC_A_F1CODE, 0);
      rd(`SRC_A_LOCK, 5);
      wrap_up();
   end
endmodule : src_ctrl_tb_top
